//--- cfm_regs.svh
// Constants of the clock fault monitor: sizes, limits and timing counts.
// Assumes inclusion by the package and the design modules of this block.
`ifndef CFM_REGS_SVH
`define CFM_REGS_SVH

// ----------------------------------------------------------------------------
// Channel map
// ----------------------------------------------------------------------------
`define CFM_NUM_CH       6
`define CFM_NUM_MON      7
`define CFM_CH_AUX0      4
`define CFM_CH_AUX1      5
`define CFM_CH_XTAL      6
`define CFM_MAX_MON      4
`define CFM_NUM_LOOP     3
`define CFM_LOOP_D       2

// ----------------------------------------------------------------------------
// Reference sources for the zero-ppm measurement
// ----------------------------------------------------------------------------
`define CFM_REFSEL_REF   3'h0
`define CFM_REFSEL_XTAL  3'h4

// ----------------------------------------------------------------------------
// Limits and timing
// ----------------------------------------------------------------------------
`define CFM_CLK_MHZ      250
`define CFM_GAP_MIN_MHZ  10
`define CFM_GAP_MAX_PER  (`CFM_CLK_MHZ / `CFM_GAP_MIN_MHZ)
`define CFM_GAP_GROUP    8
`define CFM_GAP_MAX_MISS 2
`define CFM_GAP_SLACK    3
`define CFM_FAST_PPM     4000
`define CFM_FAST_FACTOR  (1000000 / `CFM_FAST_PPM)
`define CFM_PREC_MAX     8000
`define CFM_LOL_MIN      1
`define CFM_LOL_MAX      100000
`define CFM_OOF_WIN      16000000
`define CFM_FAST_WIN     1000

`endif

//--- cfm_pkg.sv
// Types shared by the clock fault monitor modules.
// Assumes cfm_regs.svh is on the include path.
`include "cfm_regs.svh"

package cfm_pkg;

  // --------------------------------------------------------------------------
  // Per-channel monitor setup
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [13:0] losLimit;
    logic [7:0]  nomPeriod;
    logic [23:0] nomCount;
    logic [12:0] oofLimit;
    logic [12:0] oofHyst;
    logic        preciseEn;
    logic        fastEn;
    logic        gapped;
  } cfm_chCfg_s;

  // --------------------------------------------------------------------------
  // Per-loop lock supervision setup and state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [16:0] lolSet;
    logic [16:0] lolClear;
    logic [15:0] lolDelay;
    logic [2:0]  inSel;
  } cfm_loopCfg_s;

  typedef struct packed {
    logic [2:0] lock_lost;
    logic [5:0] freq_out_of_range;
    logic [6:0] signal_lost;
  } cfm_status_s;

  typedef enum logic [1:0] {
    LOL_LOST   = 2'b00,
    LOL_SETTLE = 2'b01,
    LOL_LOCKED = 2'b11
  } cfm_lolState_e;

endpackage

//--- cfm_chan_mon.sv
// One input clock monitor: missing edges, precise and fast frequency, gaps.
// Assumes the input is synchronous to clk and window ticks come from the top.
`timescale 1ns/1ps
`include "cfm_regs.svh"

module cfm_chan_mon
  import cfm_pkg::*;
#(
  parameter bit IS_XTAL = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       clkIn,
  input  wire logic       monEn,
  input  cfm_chCfg_s      cfg,
  input  wire logic       winTick,
  input  wire logic       fastTick,
  output logic            signal_lost,
  output logic            freq_out_of_range,
  output logic            gapOk
);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic        prevIn;
  logic        edgeSeen;
  logic [15:0] sinceEdge;
  logic [15:0] losTimeout;
  logic [23:0] precCnt;
  logic [23:0] precDev;
  logic [23:0] fastCnt;
  logic [23:0] fastLast;
  logic [23:0] fastDev;
  logic        oofPrec;
  logic        oofFast;
  logic [7:0]  tickDiv;
  logic [2:0]  slot;
  logic [3:0]  seenCnt;

  // --------------------------------------------------------------------------
  // Edge timing and missing-edge detection
  // --------------------------------------------------------------------------
  assign edgeSeen   = clkIn & ~prevIn;
  assign losTimeout = cfg.gapped & gapOk ? 16'(cfg.losLimit) * 16'(`CFM_GAP_SLACK) : 16'(cfg.losLimit);

  // Cycles since the last rising edge, saturating
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prevIn    <= 1'b0;
      sinceEdge <= 16'h0;
    end else begin
      prevIn <= clkIn;
      if (edgeSeen) begin
        sinceEdge <= 16'h0;
      end else if (sinceEdge != 16'hffff) begin
        sinceEdge <= sinceEdge + 16'h1;
      end
    end
  end

  // Loss once the gap exceeds the programmed tolerance
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      signal_lost <= 1'b0;
    end else begin
      signal_lost <= monEn & ~edgeSeen & (sinceEdge >= losTimeout);
    end
  end

  // --------------------------------------------------------------------------
  // Gapped clock qualification
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tickDiv <= 8'h0;
      slot    <= 3'h0;
      seenCnt <= 4'h0;
      gapOk   <= 1'b0;
    end else if (!cfg.gapped || !monEn) begin
      tickDiv <= 8'h0;
      slot    <= 3'h0;
      seenCnt <= 4'h0;
      gapOk   <= 1'b0;
    end else if (tickDiv + 8'h1 >= cfg.nomPeriod) begin
      tickDiv <= 8'h0;
      slot    <= slot + 3'h1;
      if (slot == 3'(`CFM_GAP_GROUP - 1)) begin
        gapOk   <= (cfg.nomPeriod <= 8'(`CFM_GAP_MAX_PER)) &&
                   (seenCnt + 4'(edgeSeen) >= 4'(`CFM_GAP_GROUP - `CFM_GAP_MAX_MISS));
        seenCnt <= 4'h0;
      end else if (edgeSeen && seenCnt != 4'(`CFM_GAP_GROUP)) begin
        seenCnt <= seenCnt + 4'h1;
      end
    end else begin
      tickDiv <= tickDiv + 8'h1;
      if (edgeSeen && seenCnt != 4'(`CFM_GAP_GROUP)) begin
        seenCnt <= seenCnt + 4'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Frequency monitors against the zero-ppm reference
  // --------------------------------------------------------------------------
  assign precDev = precCnt > cfg.nomCount ? precCnt - cfg.nomCount : cfg.nomCount - precCnt;
  assign fastDev = fastCnt > fastLast ? fastCnt - fastLast : fastLast - fastCnt;

  // Precise window count with hysteresis on release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      precCnt <= 24'h0;
      oofPrec <= 1'b0;
    end else if (winTick) begin
      precCnt <= 24'(edgeSeen);
      if (precDev > 24'(cfg.oofLimit)) begin
        oofPrec <= 1'b1;
      end else if (precDev + 24'(cfg.oofHyst) <= 24'(cfg.oofLimit)) begin
        oofPrec <= 1'b0;
      end
    end else begin
      precCnt <= precCnt + 24'(edgeSeen);
    end
  end

  // Fast monitor flags a jump between two short windows
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fastCnt  <= 24'h0;
      fastLast <= 24'h0;
      oofFast  <= 1'b0;
    end else if (fastTick) begin
      fastCnt  <= 24'(edgeSeen);
      fastLast <= fastCnt;
      oofFast  <= 32'(fastDev) * 32'(`CFM_FAST_FACTOR) > 32'(fastLast);
    end else begin
      fastCnt <= fastCnt + 24'(edgeSeen);
    end
  end

  // Combined status; gaps of a valid gapped clock never trip the fast path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_out_of_range <= 1'b0;
    end else begin
      freq_out_of_range <= !IS_XTAL && monEn && ((cfg.preciseEn && oofPrec) ||
             (cfg.fastEn && oofFast && !(cfg.gapped && gapOk)));
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  los_timeout_a: assert property ((monEn && !edgeSeen && sinceEdge >= losTimeout) |=> signal_lost)
    else $error("missing edge not flagged");
  xtal_nofreq_a: assert property (IS_XTAL |-> !freq_out_of_range)
    else $error("crystal monitor raised a frequency alarm");

endmodule

//--- cfm_monitor.sv
// Top of the clock fault monitor: channel monitors, lock supervision, status.
// Assumes all inputs synchronous to clk; configuration held steady by software.
`timescale 1ns/1ps
`include "cfm_regs.svh"

module cfm_monitor
  import cfm_pkg::*;
#(
  parameter int OOF_WIN_EDGES  = `CFM_OOF_WIN,
  parameter int FAST_WIN_EDGES = `CFM_FAST_WIN
) (
  input  wire logic   clk,
  input  wire logic   rst_b,
  input  wire logic   clk_in_0,
  input  wire logic   clk_in_1,
  input  wire logic   clk_in_2,
  input  wire logic   refIn,
  input  wire logic   aux_in_0,
  input  wire logic   aux_in_1,
  input  wire logic   crystal_in,
  input  wire logic [5:0]  monEnable,
  input  cfm_chCfg_s  chanCfg [`CFM_NUM_CH],
  input  wire logic [13:0] crystalLosLimit,
  input  wire logic [2:0]  refSel,
  input  cfm_loopCfg_s loopCfg [`CFM_NUM_LOOP],
  input  wire logic [16:0] loopFreqErr [`CFM_NUM_LOOP],
  input  wire logic   keepOutputsOnXtalLoss,
  input  wire logic [15:0] intMask,
  input  wire logic [15:0] stickyClear,
  output cfm_status_s statusLive,
  output cfm_status_s statusSticky,
  output logic        irq_n,
  output logic        lock_lost_n_loop_a,
  output logic        lock_lost_n_loop_c,
  output logic        lock_lost_n_loop_d,
  output logic        crystal_signal_lost,
  output logic        outputsEnabled,
  output logic [2:0]  holdoverReq,
  output logic [5:0]  selectable
);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (OOF_WIN_EDGES < 2 || FAST_WIN_EDGES < 2 || FAST_WIN_EDGES > OOF_WIN_EDGES) begin : bad_windows
    $error("frequency window lengths out of range");
  end

  logic [6:0]  rawIn;
  logic [6:0]  monEn;
  logic [5:0]  effEn;
  logic [6:0]  losNow;
  logic [6:0]  oofNow;
  logic [6:0]  gapOkNow;
  logic        refMux;
  logic        refPrev;
  logic        refEdge;
  logic [31:0] winCnt;
  logic [31:0] fastCnt;
  logic        winTick;
  logic        fastTick;
  logic [2:0]  lolNow;
  cfm_status_s liveNow;
  logic [15:0] stickyMasked;
  cfm_chCfg_s  xtalCfg;

  // --------------------------------------------------------------------------
  // Channel enables: the first four requested inputs win
  // --------------------------------------------------------------------------
  function automatic logic [5:0] first_four(input logic [5:0] req);
    logic [5:0] grant;
    logic [2:0] taken;
    grant = 6'h0;
    taken = 3'h0;
    for (int i = 0; i < `CFM_NUM_CH; i++) begin
      if (req[i] && taken < 3'(`CFM_MAX_MON)) begin
        grant[i] = 1'b1;
        taken    = taken + 3'h1;
      end
    end
    return grant;
  endfunction

  assign effEn = first_four(monEnable);
  assign monEn = {1'b1, effEn};
  assign rawIn = {crystal_in, aux_in_1, aux_in_0, refIn, clk_in_2, clk_in_1, clk_in_0};

  // --------------------------------------------------------------------------
  // Zero-ppm reference selection and measurement windows
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (refSel)
      `CFM_REFSEL_REF:  refMux = refIn;
      3'h1:             refMux = clk_in_0;
      3'h2:             refMux = clk_in_1;
      3'h3:             refMux = clk_in_2;
      `CFM_REFSEL_XTAL: refMux = crystal_in;
      default:          refMux = refIn;
    endcase
  end

  assign refEdge  = refMux & ~refPrev;
  assign winTick  = refEdge && (winCnt == 32'(OOF_WIN_EDGES - 1));
  assign fastTick = refEdge && (fastCnt == 32'(FAST_WIN_EDGES - 1));

  // Count reference edges to close each window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refPrev <= 1'b0;
      winCnt  <= 32'h0;
      fastCnt <= 32'h0;
    end else begin
      refPrev <= refMux;
      if (refEdge) begin
        winCnt  <= winTick ? 32'h0 : winCnt + 32'h1;
        fastCnt <= fastTick ? 32'h0 : fastCnt + 32'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Channel monitors; the crystal gets loss detection only
  // --------------------------------------------------------------------------
  always_comb begin
    xtalCfg          = '0;
    xtalCfg.losLimit = crystalLosLimit;
  end

  for (genvar c = 0; c < `CFM_NUM_MON; c++) begin : chan
    cfm_chan_mon #(
      .IS_XTAL (c == `CFM_CH_XTAL)
    ) u_mon (
      .clk      (clk),
      .rst_b    (rst_b),
      .clkIn    (rawIn[c]),
      .monEn    (monEn[c]),
      .cfg      (c == `CFM_CH_XTAL ? xtalCfg : chanCfg[c % `CFM_NUM_CH]),
      .winTick  (winTick),
      .fastTick (fastTick),
      .signal_lost      (losNow[c]),
      .freq_out_of_range      (oofNow[c]),
      .gapOk    (gapOkNow[c])
    );
  end

  // --------------------------------------------------------------------------
  // Lock-loss supervision per loop
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < `CFM_NUM_LOOP; g++) begin : loop
    cfm_lolState_e st;
    logic [15:0]   timer;
    logic          gapHold;
    logic [2:0]    sel;

    assign sel     = loopCfg[g].inSel;
    assign gapHold = sel < 3'(`CFM_NUM_CH) && chanCfg[sel].gapped && gapOkNow[sel];
    assign lolNow[g] = st != LOL_LOCKED;

    // Set on the upper threshold, clear on the lower one after the delay
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        st    <= LOL_LOST;
        timer <= 16'h0;
      end else begin
        unique case (st)
          LOL_LOST: begin
            timer <= 16'h0;
            if (loopFreqErr[g] <= loopCfg[g].lolClear) begin
              st <= LOL_SETTLE;
            end
          end
          LOL_SETTLE: begin
            if (loopFreqErr[g] > loopCfg[g].lolClear) begin
              st <= LOL_LOST;
            end else if (timer >= loopCfg[g].lolDelay) begin
              st <= LOL_LOCKED;
            end else begin
              timer <= timer + 16'h1;
            end
          end
          LOL_LOCKED: begin
            if (loopFreqErr[g] > loopCfg[g].lolSet && !gapHold) begin
              st <= LOL_LOST;
            end
          end
          default: st <= LOL_LOST;
        endcase
      end
    end

    lol_delay_a: assert property ((st == LOL_SETTLE && timer < loopCfg[g].lolDelay) |=> st != LOL_LOCKED)
      else $error("lock declared before the clear delay ran out");
    lol_set_a: assert property ((st == LOL_LOCKED && loopFreqErr[g] > loopCfg[g].lolSet && !gapHold)
                                |=> st == LOL_LOST)
      else $error("lock loss not set above the set threshold");
  end

  // --------------------------------------------------------------------------
  // Live and sticky status
  // --------------------------------------------------------------------------
  assign liveNow.signal_lost  = losNow;
  assign liveNow.freq_out_of_range  = oofNow[5:0];
  assign liveNow.lock_lost  = lolNow;
  assign stickyMasked = statusSticky & ~intMask;

  // Live view of every indicator
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Every loop starts out of lock, so the live lock bits come up set
      statusLive <= '{lock_lost: 3'h7, freq_out_of_range: 6'h0, signal_lost: 7'h0};
    end else begin
      statusLive <= liveNow;
    end
  end

  // Sticky bits: write one clears, a fresh event in the same cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      statusSticky <= '0;
    end else begin
      statusSticky <= (statusSticky & ~stickyClear) | liveNow;
    end
  end

  // Interrupt held low while any unmasked sticky bit stays set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|stickyMasked;
    end
  end

  // --------------------------------------------------------------------------
  // Pins, output gating, holdover and selection candidates
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_lost_n_loop_a  <= 1'b0;
      lock_lost_n_loop_c  <= 1'b0;
      lock_lost_n_loop_d  <= 1'b0;
      crystal_signal_lost <= 1'b0;
      outputsEnabled      <= 1'b0;
    end else begin
      lock_lost_n_loop_a  <= ~lolNow[0];
      lock_lost_n_loop_c  <= ~lolNow[1];
      lock_lost_n_loop_d  <= ~lolNow[2];
      crystal_signal_lost <= losNow[`CFM_CH_XTAL];
      outputsEnabled      <= ~losNow[`CFM_CH_XTAL] | keepOutputsOnXtalLoss;
    end
  end

  // Holdover follows loss on the chosen input; paired aux inputs never count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      holdoverReq <= 3'h0;
    end else begin
      for (int l = 0; l < `CFM_NUM_LOOP; l++) begin
        holdoverReq[l] <= loopCfg[l].inSel < 3'(`CFM_NUM_CH) && losNow[loopCfg[l].inSel] &&
                          !(loopCfg[l].inSel >= 3'(`CFM_CH_AUX0) &&
                            effEn[`CFM_CH_AUX0] && effEn[`CFM_CH_AUX1]);
      end
    end
  end

  // Monitored inputs free of both alarms may be picked by automatic selection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      selectable <= 6'h0;
    end else begin
      selectable <= effEn & ~losNow[5:0] & ~oofNow[5:0];
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sticky_set_a: assert property (rst_b |=> ((statusSticky & $past(liveNow)) == $past(liveNow)))
    else $error("event lost against a sticky clear");
  sticky_hold_a: assert property ((statusSticky[0] && !stickyClear[0]) |=> statusSticky[0])
    else $error("sticky bit dropped without a clear");
  irq_level_a: assert property (1'b1 |=> (irq_n == !$past(|stickyMasked)))
    else $error("interrupt level does not follow masked sticky bits");
  outs_gate_a: assert property ((losNow[`CFM_CH_XTAL] && !keepOutputsOnXtalLoss) |=> !outputsEnabled)
    else $error("outputs left on during crystal loss");
  lol_pin_a: assert property (lock_lost_n_loop_d == !statusLive.lock_lost[2])
    else $error("lock pin disagrees with live status");
  mon_count_a: assert property ($countones(effEn) <= `CFM_MAX_MON)
    else $error("more than four inputs monitored");
  aux_hold_a: assert property ((effEn[`CFM_CH_AUX0] && effEn[`CFM_CH_AUX1] &&
                                loopCfg[`CFM_LOOP_D].inSel >= 3'(`CFM_CH_AUX0))
                               |=> !holdoverReq[`CFM_LOOP_D])
    else $error("paired aux input drove holdover");
  select_ok_a: assert property ((selectable & (statusLive.signal_lost[5:0] | statusLive.freq_out_of_range)) == 6'h0)
    else $error("alarmed input offered for selection");

  // Status views and pins stay in step with the monitors, the sticky clears and the keep input
  xtal_pin_a: assert property (crystal_signal_lost == statusLive.signal_lost[`CFM_CH_XTAL])
    else $error("crystal pin disagrees with live status");
  lock_pin_a: assert property (lock_lost_n_loop_a == !statusLive.lock_lost[0])
    else $error("loop a lock pin disagrees with live status");
  live_follow_a: assert property (rst_b |=> statusLive == $past(liveNow))
    else $error("live status does not follow the monitors");
  sticky_clear_a: assert property ((stickyClear[0] && !liveNow.signal_lost[0]) |=> !statusSticky[0])
    else $error("sticky bit survived a clear without a new event");
  outs_keep_a: assert property ((rst_b && keepOutputsOnXtalLoss) |=> outputsEnabled)
    else $error("outputs dropped although kept on");

  irq_seen_c: cover property ($fell(irq_n) ##[1:50] $rose(irq_n));
  lock_seen_c: cover property ($rose(lock_lost_n_loop_a));
  hold_seen_c: cover property ($rose(holdoverReq[0]));
  aux_pair_c: cover property (effEn[`CFM_CH_AUX0] && effEn[`CFM_CH_AUX1] && losNow[`CFM_CH_AUX0]);

endmodule

//--- cfm_host_model.sv
// Host model: answers the interrupt by clearing the sticky bits it reads.
// Assumes status and irq_n come from cfm_monitor on the same clock.
`timescale 1ns/1ps

module cfm_host_model
  import cfm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        serviceEn,
  input  wire logic        irq_n,
  input  cfm_status_s      statusSticky,
  input  wire logic [15:0] manualClear,
  output logic [15:0]      stickyClear
);
  // --------------------------------------------------------------------------
  // Interrupt service
  // --------------------------------------------------------------------------
  logic [15:0] serviced;

  // One-cycle write-one-to-clear of every set sticky bit, masked ones included
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serviced <= 16'h0;
    end else begin
      serviced <= (serviceEn && !irq_n && serviced == 16'h0) ? statusSticky : 16'h0;
    end
  end

  // Bench clears merge with the serviced ones
  assign stickyClear = serviced | manualClear;
endmodule

//--- testbench.sv
// Testbench of the clock fault monitor: loss, crystal, lock and interrupt.
// Assumes cfm_pkg, cfm_monitor and cfm_host_model are compiled first.
`timescale 1ns/1ps

module testbench
  import cfm_pkg::*;
;
  // --------------------------------------------------------------------------
  // Stimulus and design
  // --------------------------------------------------------------------------
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic [6:0]   run = 7'h7f;
  logic [6:0]   inClk = 7'h0;
  logic [1:0]   phase = 2'h0;
  logic         keepOn = 1'b0;
  logic         hostEn = 1'b0;
  logic [15:0]  intMask = 16'hff80;
  logic [15:0]  manClr = 16'h0;
  logic [15:0]  clrBits;
  cfm_chCfg_s   chCfg [6];
  cfm_loopCfg_s lpCfg [3];
  logic [16:0]  lpErr [3];
  cfm_status_s  live;
  cfm_status_s  sticky;
  logic         irq_n;
  logic         lockA;
  logic         xtalLost;
  logic         outEn;
  logic [5:0]   selectable;
  logic [5:0]   monReq = 6'h3f;
  logic [2:0]   hold;
  logic [1:0]   lockCD;
  int           badCount = 0;
  int           checks = 0;

  // Clock and monitored inputs at a quarter of its rate
  always #2 clk = ~clk;
  always_ff @(posedge clk) begin
    phase <= phase + 2'h1;
    inClk <= run & {7{phase[1]}};
  end

  cfm_monitor #(.OOF_WIN_EDGES(64), .FAST_WIN_EDGES(8)) dut (
    .clk(clk), .rst_b(rst_b), .clk_in_0(inClk[0]), .clk_in_1(inClk[1]), .clk_in_2(inClk[2]),
    .refIn(inClk[3]), .aux_in_0(inClk[4]), .aux_in_1(inClk[5]), .crystal_in(inClk[6]),
    .monEnable(monReq), .chanCfg(chCfg), .crystalLosLimit(14'h14), .refSel(3'h0),
    .loopCfg(lpCfg), .loopFreqErr(lpErr), .keepOutputsOnXtalLoss(keepOn), .intMask(intMask),
    .stickyClear(clrBits), .statusLive(live), .statusSticky(sticky), .irq_n(irq_n),
    .lock_lost_n_loop_a(lockA), .lock_lost_n_loop_c(lockCD[0]), .lock_lost_n_loop_d(lockCD[1]),
    .crystal_signal_lost(xtalLost), .outputsEnabled(outEn), .holdoverReq(hold), .selectable(selectable));

  cfm_host_model host (
    .clk(clk), .rst_b(rst_b), .serviceEn(hostEn), .irq_n(irq_n), .statusSticky(sticky),
    .manualClear(manClr), .stickyClear(clrBits));

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic clear(input logic [15:0] m);
    @(posedge clk) manClr <= m;
    @(posedge clk) manClr <= 16'h0;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task print_verdict;
    $display("checks %0d, mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 6; i++) begin
      chCfg[i] = '{losLimit: 14'h14, nomPeriod: 8'h04, nomCount: 24'h40, oofLimit: 13'h100,
                   oofHyst: 13'h10, preciseEn: 1'b1, fastEn: 1'b1, gapped: 1'b0};
    end
    for (int i = 0; i < 3; i++) begin
      lpCfg[i] = '{lolSet: 17'h64, lolClear: 17'h0a, lolDelay: 16'h5,
                   inSel: (i == 0) ? 3'h1 : (i == 1) ? 3'h0 : 3'h4};
      lpErr[i] = 17'h32;
    end
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    tick(600);
    clear(16'hffff);
    tick(5);
    check("selectable", 16'h0f, selectable);
    check("outputsEnabled", 16'h1, outEn);
    check("irq_n", 16'h1, irq_n);
    check("live los", 16'h0, live.signal_lost);
    check("lock pin a", 16'h0, lockA);
    check("lock pins c d", 16'h0, lockCD);
    check("holdover", 16'h0, hold);
    // Lost edges on the first main input
    @(posedge clk) run[0] <= 1'b0;
    tick(30);
    check("live los", 16'h1, live.signal_lost);
    check("sticky los", 16'h1, sticky.signal_lost);
    check("selectable", 16'h0e, selectable);
    check("holdover", 16'h2, hold);
    check("irq_n", 16'h0, irq_n);
    clear(16'h0001);
    tick(2);
    check("sticky los", 16'h1, sticky.signal_lost);
    check("irq_n", 16'h0, irq_n);
    @(posedge clk) run[0] <= 1'b1;
    tick(30);
    @(posedge clk) hostEn <= 1'b1;
    tick(10);
    check("sticky los", 16'h0, sticky.signal_lost);
    check("irq_n", 16'h1, irq_n);
    @(posedge clk) begin
      hostEn <= 1'b0;
      intMask <= 16'hff81;
      run[0] <= 1'b0;
    end
    tick(30);
    check("masked irq_n", 16'h1, irq_n);
    check("sticky los", 16'h1, sticky.signal_lost);
    @(posedge clk) run <= 7'h3f;
    tick(30);
    clear(16'h0001);
    @(posedge clk) intMask <= 16'hff80;
    tick(5);
    // Crystal stopped
    check("crystal lost", 16'h1, xtalLost);
    check("crystal live", 16'h40, live.signal_lost);
    check("outputsEnabled", 16'h0, outEn);
    check("irq_n", 16'h0, irq_n);
    @(posedge clk) keepOn <= 1'b1;
    tick(3);
    check("outputsEnabled", 16'h1, outEn);
    @(posedge clk) run <= 7'h7f;
    tick(30);
    clear(16'h0040);
    // Lock acquisition, hold and loss on the first loop
    @(posedge clk) lpErr[0] <= 17'h5;
    tick(4);
    check("lock pin a", 16'h0, lockA);
    tick(10);
    check("lock pin a", 16'h1, lockA);
    check("live lol", 16'h0, live.lock_lost[0]);
    @(posedge clk) lpErr[0] <= 17'h32;
    tick(10);
    check("lock pin a", 16'h1, lockA);
    @(posedge clk) lpErr[0] <= 17'hc8;
    tick(4);
    check("lock pin a", 16'h0, lockA);
    check("live lol", 16'h1, live.lock_lost[0]);
    check("sticky lol", 16'h1, sticky.lock_lost[0]);
    // Both aux inputs monitored: loss of aux_in_0 must not request holdover
    @(posedge clk) begin
      monReq <= 6'h31;
      run[4] <= 1'b0;
    end
    tick(30);
    check("aux live los", 16'h10, live.signal_lost);
    check("holdover", 16'h0, hold);
    check("selectable", 16'h21, selectable);
    print_verdict();
  end

  // Watchdog over ten thousand cycles
  initial begin
    #40000;
    badCount++;
    print_verdict();
  end
endmodule
